// *** async_mem_pkg.sv ***
package async_mem_pkg;

    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int BA_W = 2;
    localparam int CS_W = 4;
    localparam int CS_SEL_W = 2;
    localparam int CNT_W = 8;

    // one extended wait cycle lasts this many port cycles
    localparam int EXT_WAIT_BLOCK = 16;
    localparam int EXT_BLK_W = 4;
    // port cycles from the wait input falling to the strobe ending
    localparam int WAIT_RELEASE_CYCLES = 4;
    localparam int FIFO_DEPTH_DEF = 4;

    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [EXT_BLK_W-1:0] BLK_LAST = 4'hF;
    localparam logic [EXT_BLK_W-1:0] BLK_ZERO = 4'h0;
    // the low sample and the final count cycle are two of the four release cycles
    localparam logic [CNT_W-1:0] RELEASE_LOAD = 8'h02;

    typedef enum {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_EXTWAIT,
        ST_RELEASE,
        ST_HOLD,
        ST_TURN
    } seq_state_t;

    typedef struct packed {
        logic is_write;
        logic [CS_SEL_W-1:0] cs_sel;
        logic [ADDR_W-1:0] addr;
        logic [BA_W-1:0] byte_bank;
        logic [DATA_W-1:0] wdata;
    } mem_req_t;

    localparam int REQ_W = $bits(mem_req_t);

    typedef struct packed {
        logic [CNT_W-1:0] turnaround_cycles;
        logic [CNT_W-1:0] read_setup_cycles;
        logic [CNT_W-1:0] read_strobe_cycles;
        logic [CNT_W-1:0] read_hold_cycles;
        logic [CNT_W-1:0] write_setup_cycles;
        logic [CNT_W-1:0] write_strobe_cycles;
        logic [CNT_W-1:0] write_hold_cycles;
        logic [CNT_W-1:0] max_ext_wait_cycles;
    } async_cfg_t;

endpackage

// *** async_memory_strobe_sequencer.sv ***
// Summary of operation
// RULE_01: phase lengths count port cycles; half rate makes a port cycle two clocks.
// RULE_02: all phase counts and the wait ceiling come from configuration inputs.
// RULE_03: a turnaround of the programmed count follows every access.
// RULE_04: a plain read lasts setup plus strobe plus hold port cycles.
// RULE_05: extended wait stretches read strobe by sixteen cycles per wait cycle.
// RULE_06: without extended wait, output-enable stays low exactly the strobe count.
// RULE_07: normal mode: chip select spans setup, strobe and hold of a read.
// RULE_08: select-strobe mode: chip select coincides with output-enable on reads.
// RULE_09: read address is valid a setup count before output-enable falls.
// RULE_10: read address stays stable a hold count after output-enable rises.
// RULE_11: byte/bank selects valid over read setup and held through read hold.
// RULE_12: output-enable rises four port cycles after wait input deasserts.
// RULE_13: a write lasts setup, strobe and hold, plus sixteen per wait cycle.
// RULE_14: write-enable stays low the strobe count plus sixteen per wait cycle.
// RULE_15: chip select coincides with write-enable in select-strobe mode, else spans setup/hold.
// RULE_16: write address valid a setup count before and a hold count after.
// RULE_17: byte/bank selects valid over write setup and held through write hold.
// RULE_18: write data is driven a setup count before write-enable falls.
// RULE_19: write data stays driven a hold count after write-enable rises.
// RULE_20: write-enable rises four port cycles after wait input deasserts.
// RULE_21: wait cycle count runs up to 255; reaching the ceiling ends with timeout.
// RULE_22: memory must raise wait four port cycles before hold would begin.
// RULE_23: memory must hold wait high and low at least two port cycles.
// RULE_24: read data is captured in the port cycle output-enable rises.
// RULE_25: data bus is not driven during reads and turnaround.

module req_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
            $error("req_fifo depth must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W:0] wr_ptr_reg;
    logic [PTR_W:0] wr_ptr_next;
    logic [PTR_W:0] rd_ptr_reg;
    logic [PTR_W:0] rd_ptr_next;
    logic push;
    logic pop;

    always_comb begin
        out_valid = (wr_ptr_reg != rd_ptr_reg);
        in_ready = !((wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W])
                     && (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]));
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
        out_data = store[rd_ptr_reg[PTR_W-1:0]];
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
        end
    end

    // storage needs no reset; only words behind the write pointer are read
    always_ff @(posedge ref_clk) begin
        if (push) begin
            store[wr_ptr_reg[PTR_W-1:0]] <= in_data;
        end
    end
endmodule

module async_memory_strobe_sequencer
    import async_mem_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic half_rate,
    input wire logic select_strobe_mode,
    input wire logic extended_wait_enable,
    input wire async_cfg_t cfg,
    input wire logic req_valid,
    output logic req_ready,
    input wire mem_req_t req,
    output logic [DATA_W-1:0] rd_data,
    output logic rd_data_valid,
    output logic wait_timeout,
    output logic [CNT_W-1:0] ext_wait_count,
    output logic busy,
    output logic [CS_W-1:0] mem_chip_select_n,
    output logic mem_output_enable_n,
    output logic mem_write_enable_n,
    output logic [BA_W-1:0] mem_byte_bank_sel,
    output logic [ADDR_W-1:0] mem_addr_bus,
    input wire logic [DATA_W-1:0] mem_data_bus_in,
    output logic [DATA_W-1:0] mem_data_bus_out,
    output logic mem_data_bus_oe,
    input wire logic mem_wait_in
);

    generate
        if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin : g_bad_fifo_depth
            $error("request FIFO depth must be a power of two of at least 2");
        end
    endgenerate

    // a programmed zero is served as one port cycle; returns the counter load
    function automatic logic [CNT_W-1:0] phase_load(input logic [CNT_W-1:0] len);
        return (len == CNT_ZERO) ? CNT_ZERO : len - CNT_ONE;
    endfunction

    mem_req_t fifo_data;
    logic fifo_valid;
    logic fifo_pop;

    req_fifo #(
        .WIDTH(REQ_W),
        .DEPTH(FIFO_DEPTH)
    ) u_req_fifo (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data(req),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    seq_state_t state_reg;
    seq_state_t state_next;
    mem_req_t acc_reg;
    mem_req_t acc_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [EXT_BLK_W-1:0] blk_reg;
    logic [EXT_BLK_W-1:0] blk_next;
    logic [CNT_W-1:0] ewc_reg;
    logic [CNT_W-1:0] ewc_next;
    logic wait_seen_reg;
    logic wait_seen_next;
    logic half_phase_reg;
    logic half_phase_next;
    logic tick;
    logic last;
    logic finish_strobe;
    logic timeout_now;
    logic start_now;

    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    logic timeout_reg;
    logic timeout_next;
    logic [CS_W-1:0] cs_n_reg;
    logic [CS_W-1:0] cs_n_next;
    logic oe_n_reg;
    logic oe_n_next;
    logic we_n_reg;
    logic we_n_next;
    logic [BA_W-1:0] ba_reg;
    logic [BA_W-1:0] ba_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic [DATA_W-1:0] dout_reg;
    logic [DATA_W-1:0] dout_next;
    logic doe_reg;
    logic doe_next;
    logic in_access;
    logic strobe_act;
    logic cs_act;

    // port cycle strobe: every clock at full rate, every second clock at half rate
    always_comb begin
        half_phase_next = half_rate ? !half_phase_reg : 1'b0;
        tick = !half_rate || half_phase_reg; // [RULE_01]
        last = tick && (cnt_reg == CNT_ZERO);
    end

    always_comb begin
        state_next = state_reg;
        acc_next = acc_reg;
        cnt_next = cnt_reg;
        blk_next = blk_reg;
        ewc_next = ewc_reg;
        wait_seen_next = wait_seen_reg;
        rd_data_next = rd_data_reg;
        rd_valid_next = 1'b0;
        timeout_next = 1'b0;
        fifo_pop = 1'b0;
        finish_strobe = 1'b0;
        timeout_now = 1'b0;
        start_now = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                start_now = tick;
            end
            ST_SETUP: begin
                if (last) begin
                    state_next = ST_STROBE;
                    cnt_next = phase_load(acc_reg.is_write ? cfg.write_strobe_cycles
                                                           : cfg.read_strobe_cycles);
                end
            end
            ST_STROBE: begin
                // wait is noticed anywhere in the strobe, so a memory meeting
                // the four-cycle setup before hold is caught whenever the strobe lasts four or more port cycles
                if (extended_wait_enable && mem_wait_in) begin
                    wait_seen_next = 1'b1; // [RULE_22]
                end
                if (last) begin
                    if (extended_wait_enable && (wait_seen_reg || mem_wait_in)) begin
                        state_next = ST_EXTWAIT; // [RULE_05] [RULE_13]
                        blk_next = BLK_ZERO;
                    end else begin
                        finish_strobe = 1'b1; // [RULE_06] [RULE_04]
                    end
                end
            end
            ST_EXTWAIT: begin
                if (tick) begin
                    blk_next = blk_reg + 1'b1;
                    if (blk_reg == BLK_LAST) begin
                        ewc_next = ewc_reg + CNT_ONE; // [RULE_05] [RULE_14]
                        if (ewc_reg + CNT_ONE >= cfg.max_ext_wait_cycles) begin
                            timeout_now = 1'b1; // [RULE_21]
                        end
                    end
                    if (timeout_now) begin
                        timeout_next = 1'b1;
                        finish_strobe = 1'b1;
                    end else if (!mem_wait_in) begin
                        // wait is trusted to stand two port cycles, so one low sample suffices
                        state_next = ST_RELEASE; // [RULE_23]
                        cnt_next = RELEASE_LOAD;
                    end
                end
            end
            ST_RELEASE: begin
                if (last) begin
                    finish_strobe = 1'b1; // [RULE_12] [RULE_20]
                end
            end
            ST_HOLD: begin
                if (last) begin
                    state_next = ST_TURN;
                    cnt_next = phase_load(cfg.turnaround_cycles); // [RULE_03]
                end
            end
            ST_TURN: begin
                if (last) begin
                    // a waiting request starts on the edge that ends turnaround, so the gap is exact
                    state_next = ST_IDLE;
                    start_now = 1'b1; // [RULE_03]
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (start_now && fifo_valid) begin
            fifo_pop = 1'b1;
            acc_next = fifo_data;
            state_next = ST_SETUP;
            ewc_next = CNT_ZERO;
            wait_seen_next = 1'b0;
            cnt_next = phase_load(fifo_data.is_write ? cfg.write_setup_cycles
                                                     : cfg.read_setup_cycles); // [RULE_02]
        end
        if (finish_strobe) begin
            state_next = ST_HOLD;
            cnt_next = phase_load(acc_reg.is_write ? cfg.write_hold_cycles
                                                   : cfg.read_hold_cycles);
            if (!acc_reg.is_write) begin
                // sampled while output-enable is still low, on the edge that raises it
                rd_data_next = mem_data_bus_in; // [RULE_24]
                rd_valid_next = 1'b1;
            end
        end else if (state_next == state_reg && tick && state_reg != ST_IDLE
                     && state_reg != ST_EXTWAIT && cnt_reg != CNT_ZERO) begin
            cnt_next = cnt_reg - CNT_ONE;
        end
    end

    // pins follow the next state so they change on the same edge as the phase
    always_comb begin
        in_access = (state_next == ST_SETUP) || (state_next == ST_STROBE)
                    || (state_next == ST_EXTWAIT) || (state_next == ST_RELEASE)
                    || (state_next == ST_HOLD);
        strobe_act = (state_next == ST_STROBE) || (state_next == ST_EXTWAIT)
                     || (state_next == ST_RELEASE);
        cs_act = select_strobe_mode ? strobe_act : in_access; // [RULE_07] [RULE_08] [RULE_15]
        cs_n_next = '1;
        if (cs_act) begin
            cs_n_next[acc_next.cs_sel] = 1'b0;
        end
        oe_n_next = !(strobe_act && !acc_next.is_write); // [RULE_06]
        we_n_next = !(strobe_act && acc_next.is_write); // [RULE_14]
        addr_next = in_access ? acc_next.addr : addr_reg; // [RULE_09] [RULE_10] [RULE_16]
        ba_next = in_access ? acc_next.byte_bank : ba_reg; // [RULE_11] [RULE_17]
        dout_next = in_access ? acc_next.wdata : dout_reg; // [RULE_18]
        doe_next = in_access && acc_next.is_write; // [RULE_19] [RULE_25]
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            acc_reg <= '0;
            cnt_reg <= CNT_ZERO;
            blk_reg <= BLK_ZERO;
            ewc_reg <= CNT_ZERO;
            wait_seen_reg <= 1'b0;
            half_phase_reg <= 1'b0;
            rd_data_reg <= '0;
            rd_valid_reg <= 1'b0;
            timeout_reg <= 1'b0;
            cs_n_reg <= '1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            ba_reg <= '0;
            addr_reg <= '0;
            dout_reg <= '0;
            doe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            cnt_reg <= cnt_next;
            blk_reg <= blk_next;
            ewc_reg <= ewc_next;
            wait_seen_reg <= wait_seen_next;
            half_phase_reg <= half_phase_next;
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            timeout_reg <= timeout_next;
            cs_n_reg <= cs_n_next;
            oe_n_reg <= oe_n_next;
            we_n_reg <= we_n_next;
            ba_reg <= ba_next;
            addr_reg <= addr_next;
            dout_reg <= dout_next;
            doe_reg <= doe_next;
        end
    end

    always_comb begin
        rd_data = rd_data_reg;
        rd_data_valid = rd_valid_reg;
        wait_timeout = timeout_reg;
        ext_wait_count = ewc_reg;
        busy = (state_reg != ST_IDLE);
        mem_chip_select_n = cs_n_reg;
        mem_output_enable_n = oe_n_reg;
        mem_write_enable_n = we_n_reg;
        mem_byte_bank_sel = ba_reg;
        mem_addr_bus = addr_reg;
        mem_data_bus_out = dout_reg;
        mem_data_bus_oe = doe_reg;
    end
endmodule

// *** amss_chk.sv ***
module amss_chk
    import async_mem_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic half_rate,
    input wire logic select_strobe_mode,
    input wire logic extended_wait_enable,
    input wire async_cfg_t cfg,
    input wire logic rd_data_valid,
    input wire logic wait_timeout,
    input wire logic [CNT_W-1:0] ext_wait_count,
    input wire logic [CS_W-1:0] mem_chip_select_n,
    input wire logic mem_output_enable_n,
    input wire logic mem_write_enable_n,
    input wire logic [BA_W-1:0] mem_byte_bank_sel,
    input wire logic [ADDR_W-1:0] mem_addr_bus,
    input wire logic [DATA_W-1:0] mem_data_bus_out,
    input wire logic mem_data_bus_oe,
    input wire logic mem_wait_in
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic cs_on;
    logic wr_reg;
    int strobe_reg;
    int cs_len_reg;
    int gap_reg;
    int rate;
    assign cs_on = mem_chip_select_n != 4'hF;
    assign rate = half_rate ? 2 : 1;
    function automatic int z1(logic [CNT_W-1:0] v);
        return (v == 8'h00) ? 1 : int'(v);
    endfunction
    // gap starts large so the first access after reset is not judged as a turnaround
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            strobe_reg <= 0;
            cs_len_reg <= 0;
            gap_reg <= 1000;
            wr_reg <= 1'b0;
        end else begin
            strobe_reg <= (!mem_output_enable_n || !mem_write_enable_n) ? strobe_reg + 1 : 0;
            cs_len_reg <= cs_on ? cs_len_reg + 1 : 0;
            gap_reg <= cs_on ? 0 : gap_reg + 1;
            wr_reg <= cs_on && (wr_reg || !mem_write_enable_n);
        end
    end
    a_oe_width: assert property ($rose(mem_output_enable_n) && !extended_wait_enable
        |-> strobe_reg == z1(cfg.read_strobe_cycles) * rate) else $error("read strobe width wrong");
    a_we_width: assert property ($rose(mem_write_enable_n) && !extended_wait_enable
        |-> strobe_reg == z1(cfg.write_strobe_cycles) * rate) else $error("write strobe width wrong");
    a_access_len: assert property ($fell(cs_on) && !select_strobe_mode && !extended_wait_enable
        |-> cs_len_reg == rate * (wr_reg ? z1(cfg.write_setup_cycles) + z1(cfg.write_strobe_cycles)
        + z1(cfg.write_hold_cycles) : z1(cfg.read_setup_cycles) + z1(cfg.read_strobe_cycles)
        + z1(cfg.read_hold_cycles))) else $error("access length wrong");
    a_turn_gap: assert property ($rose(cs_on) |-> gap_reg >= z1(cfg.turnaround_cycles) * rate)
        else $error("turnaround too short");
    a_ss_follow: assert property (select_strobe_mode
        |-> cs_on == !(mem_output_enable_n && mem_write_enable_n)) else $error("select not with strobe");
    a_addr_hold: assert property (cs_on && $past(cs_on) && !select_strobe_mode
        |-> $stable(mem_addr_bus) && $stable(mem_byte_bank_sel)) else $error("address moved in access");
    a_data_lead: assert property (!mem_write_enable_n
        |-> mem_data_bus_oe && $stable(mem_data_bus_out)) else $error("write data not set up");
    a_data_hold: assert property ($rose(mem_write_enable_n) |-> mem_data_bus_oe)
        else $error("write data dropped early");
    a_no_drive_read: assert property (!mem_output_enable_n || (!cs_on && !select_strobe_mode)
        |-> !mem_data_bus_oe) else $error("data bus driven on read or idle");
    a_rd_capture: assert property (rd_data_valid |-> $rose(mem_output_enable_n))
        else $error("read data not at strobe end");
    a_wait_release: assert property (extended_wait_enable && !half_rate && $fell(mem_wait_in)
        && !(mem_output_enable_n && mem_write_enable_n)
        |-> ##[3:4] ($rose(mem_output_enable_n) || $rose(mem_write_enable_n))) else $error("strobe release late");
    a_timeout_cnt: assert property (wait_timeout |-> ext_wait_count >= cfg.max_ext_wait_cycles)
        else $error("timeout below ceiling");
    c_half_read: cover property (rd_data_valid && half_rate);
    c_timeout: cover property (wait_timeout);
    c_ss_write: cover property (select_strobe_mode && !mem_write_enable_n);
endmodule

bind async_memory_strobe_sequencer amss_chk u_chk (.ref_clk, .sys_rst, .half_rate, .select_strobe_mode,
    .extended_wait_enable, .cfg, .rd_data_valid, .wait_timeout, .ext_wait_count, .mem_chip_select_n,
    .mem_output_enable_n, .mem_write_enable_n, .mem_byte_bank_sel, .mem_addr_bus, .mem_data_bus_out,
    .mem_data_bus_oe, .mem_wait_in);

// *** mem_model.sv ***
module mem_model
    import async_mem_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [CS_W-1:0] cs_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wdata_oe,
    input wire logic [31:0] wait_len,
    output logic [DATA_W-1:0] rdata,
    output logic wait_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] last = 16'h0000;
    logic sel_d = 1'b0;
    int wait_left = 0;
    initial for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
    // released bus shows the inverse of the last word so a stale capture cannot match
    assign rdata = (!oe_n && cs_n != 4'hF) ? mem[addr[3:0]] : ~last;
    assign wait_out = wait_left > 0;
    always @(posedge ref_clk) begin
        if (!oe_n && cs_n != 4'hF) last <= mem[addr[3:0]];
        if (!we_n && cs_n != 4'hF && wdata_oe) mem[addr[3:0]] <= wdata;
        sel_d <= cs_n != 4'hF;
        // raised one clock into select, well ahead of hold, and held for many cycles
        if (cs_n != 4'hF && !sel_d && wait_len > 0) wait_left <= wait_len;
        else if (wait_left > 0) wait_left <= wait_left - 1;
    end
endmodule

// *** async_memory_strobe_sequencer_bench.sv ***
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module async_memory_strobe_sequencer_bench
    import async_mem_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic half_rate = 1'b0, select_strobe_mode = 1'b0, extended_wait_enable = 1'b0, req_valid = 1'b0;
    async_cfg_t cfg = '{8'h02, 8'h01, 8'h02, 8'h01, 8'h02, 8'h04, 8'h01, 8'h08};
    mem_req_t req = '0;
    logic [DATA_W-1:0] rd_data, mem_data_bus_in, mem_data_bus_out;
    logic rd_data_valid, wait_timeout, busy, req_ready, mem_output_enable_n, mem_write_enable_n;
    logic mem_data_bus_oe, mem_wait_in;
    logic [CNT_W-1:0] ext_wait_count;
    logic [CS_W-1:0] mem_chip_select_n;
    logic [BA_W-1:0] mem_byte_bank_sel;
    logic [ADDR_W-1:0] mem_addr_bus;
    int errors = 0, checks = 0, wait_len = 0;
    logic full_seen = 1'b0, to_seen = 1'b0;

    always #2.5 ref_clk = ~ref_clk;

    async_memory_strobe_sequencer DUT (.ref_clk, .sys_rst, .half_rate, .select_strobe_mode, .extended_wait_enable,
        .cfg, .req_valid, .req_ready, .req, .rd_data, .rd_data_valid, .wait_timeout, .ext_wait_count, .busy,
        .mem_chip_select_n, .mem_output_enable_n, .mem_write_enable_n, .mem_byte_bank_sel, .mem_addr_bus,
        .mem_data_bus_in, .mem_data_bus_out, .mem_data_bus_oe, .mem_wait_in);
    mem_model MEM (.ref_clk, .cs_n(mem_chip_select_n), .oe_n(mem_output_enable_n), .we_n(mem_write_enable_n),
        .addr(mem_addr_bus), .wdata(mem_data_bus_out), .wdata_oe(mem_data_bus_oe), .wait_len,
        .rdata(mem_data_bus_in), .wait_out(mem_wait_in));

    always @(negedge ref_clk) begin
        if (req_valid && !req_ready) full_seen = 1'b1;
        if (wait_timeout === 1'b1) to_seen = 1'b1;
    end

    // request stays up across calls so back-to-back pushes never assign it twice in one step
    task push(input logic w, input logic [CS_SEL_W-1:0] s, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        req_valid <= 1'b1;
        req <= '{w, s, a, a[BA_W-1:0], d};
        do @(negedge ref_clk); while (req_ready !== 1'b1);
        @(posedge ref_clk);
    endtask
    task settle;
        int quiet;
        req_valid <= 1'b0;
        quiet = 0;
        for (int n = 0; n < 3000 && quiet < 6; n++) begin
            @(negedge ref_clk);
            quiet = (busy === 1'b0) ? quiet + 1 : 0;
        end
        if (quiet < 6) begin
            errors++;
            $display("[FAIL] %0t sequencer never went idle", $time);
        end
        @(posedge ref_clk);
    endtask
    task wr(input logic [CS_SEL_W-1:0] s, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        push(1'b1, s, a, d);
        settle;
    endtask
    task rd_chk(input logic [CS_SEL_W-1:0] s, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        push(1'b0, s, a, 16'h0000);
        req_valid <= 1'b0;
        for (int n = 0; n < 3000; n++) begin
            @(negedge ref_clk);
            if (rd_data_valid === 1'b1) break;
        end
        `CHK(rd_data_valid, 1'b1)
        `CHK(rd_data, exp)
        settle;
    endtask
    task end_test(input string n);
        $display("test %s finished, errors so far %0d", n, errors);
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 4; i++) wr(2'(i), 21'(i + 4), 16'hA5A0 + 16'(i));
        for (int i = 0; i < 4; i++) rd_chk(2'(i), 21'(i + 4), 16'hA5A0 + 16'(i));
        end_test("write_read");
        for (int i = 0; i < 6; i++) push(1'b1, 2'h1, 21'(i + 8), 16'h5A00 + 16'(i));
        settle;
        `CHK(full_seen, 1'b1)
        rd_chk(2'h1, 21'h00000C, 16'h5A04);
        end_test("fifo_fill");
        select_strobe_mode <= 1'b1;
        wr(2'h2, 21'h000003, 16'h0F0F);
        rd_chk(2'h2, 21'h000003, 16'h0F0F);
        select_strobe_mode <= 1'b0;
        end_test("select_strobe");
        half_rate <= 1'b1;
        cfg.read_hold_cycles <= 8'h00;
        wr(2'h3, 21'h000005, 16'h1234);
        rd_chk(2'h3, 21'h000005, 16'h1234);
        half_rate <= 1'b0;
        cfg.read_hold_cycles <= 8'h01;
        end_test("half_rate");
        extended_wait_enable <= 1'b1;
        cfg.read_strobe_cycles <= 8'h06;
        wait_len = 44;
        wr(2'h0, 21'h000006, 16'hBEEF);
        rd_chk(2'h0, 21'h000006, 16'hBEEF);
        `CHK(ext_wait_count, 8'h02)
        end_test("extended_wait");
        cfg.max_ext_wait_cycles <= 8'h01;
        wait_len = 100;
        to_seen = 1'b0;
        push(1'b0, 2'h0, 21'h000006, 16'h0000);
        settle;
        `CHK(to_seen, 1'b1)
        `CHK(ext_wait_count, 8'h01)
        end_test("wait_timeout");
        wrap_up;
    end

    initial begin
        #300us;
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up;
    end
endmodule
